// ### vtru_unit.sv
// Vector generation and table read addressing for the processor core
`timescale 1ns/1ps

module vtru_unit
(
  input  wire logic        clock_in,              // Core clock
  input  wire logic        resetn_in,             // Device reset, active low
  input  wire logic        high_ptr_option_in,    // Configuration: high pointer used
  // Data memory access from the core
  input  wire logic [7:0]  dm_addr_in,            // Register address
  input  wire logic [7:0]  dm_wdata_in,           // Write data
  input  wire logic        dm_we_in,              // Write strobe
  output logic      [7:0]  dm_rdata_out,          // Read data
  output logic             dm_hit_out,            // Address belongs to this block
  // Table read requests
  input  wire logic        table_read_current_page_in, // Current-page read start
  input  wire logic        table_read_last_page_in,    // Last-page read start
  input  wire logic [11:0] program_counter_in,    // Current program counter
  output logic      [11:0] pm_addr_out,           // Program memory table address
  output logic             pm_read_out,           // Program memory read strobe
  input  wire logic [14:0] pm_word_in,            // Fetched word, valid in write cycle
  output logic      [7:0]  table_low_byte_out,    // Low byte toward data memory
  output logic             table_low_valid_out,   // Low byte write strobe
  output logic             table_busy_out,        // Table read in progress
  // Interrupt sources and control
  input  wire logic        serial_done_in,        // Serial 8-bit transfer complete
  input  wire logic        timer_overflow_in,     // Timer overflow pulse
  input  wire logic        ext_int_pin_in,        // External interrupt pin
  input  wire logic        serial_enable_in,      // Serial interrupt enabled
  input  wire logic        timer_enable_in,       // Timer interrupt enabled
  input  wire logic        ext_enable_in,         // External interrupt enabled
  input  wire logic        global_enable_in,      // Global interrupt enable
  input  wire logic        stack_full_in,         // Return stack full
  output logic      [11:0] vector_out,            // Branch target
  output logic             vector_valid_out,      // Branch strobe, one cycle per interrupt, held high during reset
  output logic      [2:0]  irq_ack_out,           // Ack: [2] serial [1] timer [0] ext
  output logic      [2:0]  irq_pending_out        // Recorded requests
);

  // ==========================================================================
  // State registers
  vtru_pkg::vtru_st_t st_q;  // Registered state
  vtru_pkg::vtru_st_t st_d;  // Next state
  logic [3:0] page_nibble;  // Upper address nibble
  logic [11:0] table_addr;  // Assembled table address
  logic last_page_q;  // Remembers read kind
  logic last_page_d;  // Next read kind
  logic start;  // Any table read start

  // ==========================================================================
  // Table address assembly
  always_comb
  begin
    // Page selection
    if (last_page_q)
    begin
      page_nibble = vtru_pkg::LAST_PAGE;
    end
    else if (high_ptr_option_in)
    begin
      page_nibble = st_q.ptr_high[3:0];
    end
    else
    begin
      page_nibble = program_counter_in[11:8];
    end
    table_addr = {page_nibble, st_q.ptr_low};
  end

  // ==========================================================================
  // Next state
  always_comb
  begin
    st_d = st_q;
    last_page_d = last_page_q;
    start = table_read_current_page_in | table_read_last_page_in;
    st_d.low_valid = 1'b0;
    st_d.vector_valid = 1'b0;
    st_d.ack = 3'b000;
    st_d.ext_prev = ext_int_pin_in;
    // Register writes; result register has no write path
    if (dm_we_in && dm_addr_in == vtru_pkg::ADDR_PTR_LOW)
    begin
      st_d.ptr_low = dm_wdata_in;
    end
    if (dm_we_in && dm_addr_in == vtru_pkg::ADDR_PTR_HIGH)
    begin
      st_d.ptr_high = dm_wdata_in;
    end
    // Table read sequencer, two instruction cycles
    unique case (st_q.state)
      vtru_pkg::VTRU_IDLE:
      begin
        if (start)
        begin
          st_d.state = vtru_pkg::VTRU_FETCH;
          last_page_d = table_read_last_page_in;
        end
      end
      vtru_pkg::VTRU_FETCH:
      begin
        st_d.state = vtru_pkg::VTRU_WRITE;
      end
      vtru_pkg::VTRU_WRITE:
      begin
        st_d.state = vtru_pkg::VTRU_IDLE;
        st_d.low_byte = pm_word_in[7:0];
        st_d.low_valid = 1'b1;
        st_d.high_result = pm_word_in[14:8];
      end
      default:
      begin
        st_d.state = vtru_pkg::VTRU_IDLE;
      end
    endcase
    // Requests recorded; new events win over acknowledgement clears
    if (st_q.ack[2]) st_d.pending.serial = 1'b0;
    if (st_q.ack[1]) st_d.pending.timer = 1'b0;
    if (st_q.ack[0]) st_d.pending.ext = 1'b0;
    if (serial_done_in) st_d.pending.serial = 1'b1;
    if (timer_overflow_in) st_d.pending.timer = 1'b1;
    if (st_q.ext_prev && !ext_int_pin_in) st_d.pending.ext = 1'b1;
    // Acknowledge by priority, held off while stack full or busy
    if (global_enable_in && !stack_full_in && st_q.ack == 3'b000 &&
        st_q.state == vtru_pkg::VTRU_IDLE && !start)
    begin
      if (st_q.pending.serial && serial_enable_in)
      begin
        st_d.vector = vtru_pkg::VEC_SERIAL;
        st_d.vector_valid = 1'b1;
        st_d.ack = 3'b100;
      end
      else if (st_q.pending.timer && timer_enable_in)
      begin
        st_d.vector = vtru_pkg::VEC_TIMER;
        st_d.vector_valid = 1'b1;
        st_d.ack = 3'b010;
      end
      else if (st_q.pending.ext && ext_enable_in)
      begin
        st_d.vector = vtru_pkg::VEC_EXT;
        st_d.vector_valid = 1'b1;
        st_d.ack = 3'b001;
      end
    end
  end

  // ==========================================================================
  // State register; reset presents the reset vector
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      st_q <= '{state: vtru_pkg::VTRU_IDLE, ptr_low: vtru_pkg::PTR_RESET,
                ptr_high: vtru_pkg::PTR_RESET, high_result: 7'h00,
                low_byte: 8'h00, low_valid: 1'b0, pending: 3'b000,
                ext_prev: 1'b1, vector: vtru_pkg::VEC_RESET,
                vector_valid: 1'b1, ack: 3'b000};
      last_page_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      last_page_q <= last_page_d;
    end
  end

  // ==========================================================================
  // Register reads
  always_comb
  begin
    dm_hit_out = 1'b1;
    unique case (dm_addr_in)
      vtru_pkg::ADDR_PTR_LOW: dm_rdata_out = st_q.ptr_low;
      vtru_pkg::ADDR_PTR_HIGH: dm_rdata_out = st_q.ptr_high;
      vtru_pkg::ADDR_HIGH_RESULT: dm_rdata_out = {1'b0, st_q.high_result};
      default:
      begin
        dm_rdata_out = 8'h00;
        dm_hit_out = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // Outputs
  assign pm_addr_out = table_addr;
  assign pm_read_out = (st_q.state == vtru_pkg::VTRU_FETCH);
  assign table_low_byte_out = st_q.low_byte;
  assign table_low_valid_out = st_q.low_valid;
  assign table_busy_out = (st_q.state != vtru_pkg::VTRU_IDLE);
  assign vector_out = st_q.vector;
  assign vector_valid_out = st_q.vector_valid;
  assign irq_ack_out = st_q.ack;
  assign irq_pending_out = st_q.pending;

endmodule

// ### vtru_pkg.sv
// Package of constants and carrier types for the vector and table read unit
package vtru_pkg;

  // ==========================================================================
  // Program memory vectors
  localparam logic [11:0] VEC_RESET = 12'h000;  // Reset entry
  localparam logic [11:0] VEC_SERIAL = 12'h004;  // Serial byte done entry
  localparam logic [11:0] VEC_TIMER = 12'h008;  // Timer overflow entry
  localparam logic [11:0] VEC_EXT = 12'h00c;  // External falling edge entry

  // ==========================================================================
  // Data memory addresses of the table registers
  localparam logic [7:0] ADDR_PTR_LOW = 8'h07;  // table_pointer_low
  localparam logic [7:0] ADDR_HIGH_RESULT = 8'h08;  // table_high_result
  localparam logic [7:0] ADDR_PTR_HIGH = 8'h1f;  // table_pointer_high

  // ==========================================================================
  // Reset values and fixed fields
  localparam logic [7:0] PTR_RESET = 8'h00;  // Table pointer reset value
  localparam logic [7:0] RESULT_RESET = 8'h00;  // High result reset value
  localparam logic [3:0] LAST_PAGE = 4'hf;  // Upper nibble of last page
  localparam logic [11:0] PC_RESET = 12'h000;  // Program counter after reset
  localparam int unsigned TABLE_CYCLES = 2;  // Instruction cycles per table read

  // ==========================================================================
  // Table read sequencer states
  typedef enum logic [1:0]
  {
    VTRU_IDLE = 2'b00,  // No table read in progress
    VTRU_FETCH = 2'b01,  // First cycle: program memory fetch
    VTRU_WRITE = 2'b10  // Second cycle: results written
  } vtru_state_t;

  // Interrupt request bundle
  typedef struct packed
  {
    logic serial;  // Serial byte complete
    logic timer;  // Timer overflow
    logic ext;  // External falling edge
  } vtru_irq_t;

  // Complete module state
  typedef struct packed
  {
    vtru_state_t state;  // Table sequencer
    logic [7:0] ptr_low;  // table_pointer_low
    logic [7:0] ptr_high;  // table_pointer_high
    logic [6:0] high_result;  // table_high_result bits 6..0
    logic [7:0] low_byte;  // Low byte toward data memory
    logic low_valid;  // Low byte write strobe
    vtru_irq_t pending;  // Recorded interrupt requests
    logic ext_prev;  // Previous external pin level
    logic [11:0] vector;  // Last branch vector
    logic vector_valid;  // Branch strobe
    logic [2:0] ack;  // Acknowledge pulses
  } vtru_st_t;

endpackage

// ### vtru_properties.sv
// Port timing checker of the vector and table read unit
`timescale 1ns/1ps
module vtru_properties
(
  input wire logic        clock_in,
  input wire logic        resetn_in,
  input wire logic        high_ptr_option_in,
  input wire logic        table_read_current_page_in,
  input wire logic        table_read_last_page_in,
  input wire logic [11:0] program_counter_in,
  input wire logic [11:0] pm_addr_out,
  input wire logic        pm_read_out,
  input wire logic        table_low_valid_out,
  input wire logic        stack_full_in,
  input wire logic [11:0] vector_out,
  input wire logic        vector_valid_out,
  input wire logic [2:0]  irq_ack_out
);
  // ==========================================================================
  // One clock domain, reset disables all but the reset check
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  AST_RESET_VEC: assert property (disable iff (1'b0) !resetn_in |-> vector_out == 12'h000 && vector_valid_out)
    else $error("reset vector wrong");
  AST_SERIAL_VEC: assert property (vector_valid_out && irq_ack_out[2] |-> vector_out == 12'h004)
    else $error("serial vector wrong");
  AST_TIMER_VEC: assert property (vector_valid_out && irq_ack_out[1] |-> vector_out == 12'h008)
    else $error("timer vector wrong");
  AST_EXT_VEC: assert property (vector_valid_out && irq_ack_out[0] |-> vector_out == 12'h00c)
    else $error("external vector wrong");
  AST_STACK_HOLD: assert property (stack_full_in |=> irq_ack_out == 3'b000)
    else $error("ack while stack full");
  AST_LAST_PAGE: assert property (pm_read_out && $past(table_read_last_page_in) |-> pm_addr_out[11:8] == 4'hf)
    else $error("last page nibble wrong");
  AST_CUR_PAGE: assert property (pm_read_out && !$past(table_read_last_page_in) && !high_ptr_option_in
    |-> pm_addr_out[11:8] == program_counter_in[11:8])
    else $error("current page nibble wrong");
  AST_TWO_CYCLES: assert property (pm_read_out |=> !pm_read_out ##1 table_low_valid_out)
    else $error("table read length wrong");
  // Main scenarios reached
  cover property (vector_valid_out && irq_ack_out != 3'b000);
  cover property (table_low_valid_out);
  cover property (stack_full_in && $past(stack_full_in));
endmodule
bind vtru_unit vtru_properties chk_u (.*);

// ### vtru_pm_model.sv
// Program memory model answering table fetches
`timescale 1ns/1ps
module vtru_pm_model
(
  input  wire logic        clock_in,  // Core clock
  input  wire logic        read_in,   // Fetch strobe
  input  wire logic [11:0] addr_in,   // Table address
  output logic      [14:0] word_out   // Word, valid in the write cycle
);
  // Fetched word, otherwise a changing pattern so stale data never passes
  always @(posedge clock_in)
  begin
    if (read_in)
      word_out <= {addr_in[6:0], addr_in[11:4]} ^ 15'h2b5c;
    else
      word_out <= ~word_out;
  end
endmodule

// ### testbench.sv
// Self-checking bench of the vector and table read unit
`timescale 1ns/1ps
module testbench;
  logic clock_in = 0, resetn_in = 1, high_ptr_option_in = 0, dm_we_in = 0, stack_full_in = 0;
  logic table_read_current_page_in = 0, table_read_last_page_in = 0, serial_done_in = 0;
  logic timer_overflow_in = 0, ext_int_pin_in = 1, serial_enable_in = 1, timer_enable_in = 1;
  logic ext_enable_in = 1, global_enable_in = 1, dm_hit_out, pm_read_out, table_low_valid_out;
  logic table_busy_out, vector_valid_out;
  logic [7:0] dm_addr_in = 8'h00, dm_wdata_in = 8'h00, dm_rdata_out, table_low_byte_out, pl, ph, res;
  logic [11:0] program_counter_in = 12'h000, pm_addr_out, vector_out;
  logic [14:0] pm_word_in;
  logic [2:0] irq_ack_out, irq_pending_out;
  logic [31:0] seed = 32'h9e42;
  int mismatches = 0, compares = 0;
  vtru_unit dut_u (.*);
  vtru_pm_model pm_u (.clock_in(clock_in), .read_in(pm_read_out), .addr_in(pm_addr_out), .word_out(pm_word_in));
  always #2 clock_in = ~clock_in;
  // Xorshift source of stimulus
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected program word at a table address
  function automatic logic [14:0] word_of(input logic [11:0] a);
    return {a[6:0], a[11:4]} ^ 15'h2b5c;
  endfunction
  task automatic chk(input logic [14:0] got, input logic [14:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Register write, strobe high for one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_in);
    dm_addr_in = a;
    dm_wdata_in = d;
    dm_we_in = 1'b1;
    @(negedge clock_in);
    dm_we_in = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    dm_addr_in = a;
    #1 chk(15'(dm_rdata_out), 15'(e));
    chk(15'(dm_hit_out), 15'(a == vtru_pkg::ADDR_PTR_LOW || a == vtru_pkg::ADDR_HIGH_RESULT
                              || a == vtru_pkg::ADDR_PTR_HIGH));
  endtask
  // One table read, current or last page
  task automatic tread(input logic lp);
    logic [11:0] a;
    logic [14:0] w;
    a = {lp ? 4'hf : high_ptr_option_in ? ph[3:0] : program_counter_in[11:8], pl};
    w = word_of(a);
    @(negedge clock_in);
    table_read_current_page_in = ~lp;
    table_read_last_page_in = lp;
    @(negedge clock_in);
    table_read_current_page_in = 1'b0;
    table_read_last_page_in = 1'b0;
    chk(15'(pm_addr_out), 15'(a));
    chk(15'(pm_read_out), 15'h1);
    chk(15'(table_busy_out), 15'h1);
    repeat (2) @(negedge clock_in);
    chk(15'(table_low_valid_out), 15'h1);
    chk(15'(table_low_byte_out), 15'(w[7:0]));
    res = {1'b0, w[14:8]};
    rd(8'h08, res);
  endtask
  initial
  begin
    resetn_in = 1'b0;
    repeat (16) @(negedge clock_in);
    chk(15'(vector_out), 15'h0);
    resetn_in = 1'b1;
    rd(8'h08, 8'h00);
    rd(8'h44, 8'h00);
    for (int i = 0; i < 12; i++)
    begin
      pl = 8'(rnd());
      ph = 8'(rnd());
      wr(8'h07, pl);
      rd(8'h07, pl);
      wr(8'h1f, ph);
      rd(8'h1f, ph);
      high_ptr_option_in = i[0];
      program_counter_in = 12'(rnd());
      global_enable_in = 1'b0;
      tread(i % 3 == 2);
      wr(8'h08, ~res);
      rd(8'h08, res);
      global_enable_in = 1'b1;
    end
    for (int k = 0; k < 3; k++)
    begin
      stack_full_in = (k == 1);
      @(negedge clock_in);
      serial_done_in = (k == 0);
      timer_overflow_in = (k == 1);
      ext_int_pin_in = (k != 2);
      @(negedge clock_in);
      serial_done_in = 1'b0;
      timer_overflow_in = 1'b0;
      if (k == 1)
      begin
        repeat (4) @(negedge clock_in);
        chk(15'(irq_pending_out), 15'h2);
        chk(15'(vector_valid_out), 15'h0);
        stack_full_in = 1'b0;
      end
      for (int n = 0; n < 9 && vector_valid_out !== 1'b1; n++)
        @(negedge clock_in);
      if (vector_valid_out !== 1'b1)
      begin
        mismatches++;
        $display("wrong value at %0t: no branch strobe", $time);
        results();
      end
      chk(15'(vector_out), 15'(4 * (k + 1)));
      chk(15'(irq_ack_out), 15'(3'b100 >> k));
      ext_int_pin_in = 1'b1;
    end
    results();
  end
endmodule
